// ==== rtl/fabric_csr_pkg.sv ====
package fabric_csr_pkg;

  // register byte addresses on the wishbone slave
  localparam logic [11:0] DATA_REG_ADDR = 12'h1AC;
  localparam logic [11:0] CMD_REG_ADDR  = 12'h1B0;

  // command register field positions and widths
  localparam int PEND_BIT    = 31;
  localparam int RNW_BIT     = 30;
  localparam int STEP_UP_BIT = 29;
  localparam int STEP_DN_BIT = 28;
  localparam int LANE_LSB    = 16;
  localparam int LANE_W      = 4;
  localparam int INDEX_W     = 16;

  // reset values and the index step
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [3:0]  LANE_RESET  = 4'h0;
  localparam logic [15:0] INDEX_ONE   = 16'h0001;

  // fabric-side request carrier
  typedef struct packed {
    logic        req;
    logic        rnw;
    logic [15:0] index;
    logic [3:0]  lanes;
    logic [31:0] wdata;
  } fabric_req_type;

  // fabric-side answer carrier
  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
  } fabric_rsp_type;

  // transfer sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_WAIT = 3'b100
  } xfer_state_type;

endpackage

// ==== rtl/lane_merge.sv ====
`timescale 1ns/1ps
`default_nettype none
// applies lane-select mask: returns merged word per byte lane
module lane_merge (
  // operands
  input  wire logic [31:0] old_i,
  input  wire logic [31:0] new_i,
  input  wire logic [3:0]  lanes_i,
  // result
  output logic      [31:0] merged_o
);
  // lane n governs bits 8n+7:8n
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      merged_o[n*8 +: 8] = lanes_i[n] ? new_i[n*8 +: 8] : old_i[n*8 +: 8]; // [R13]
    end
  end
endmodule
`default_nettype wire

// ==== rtl/indirect_fabric_csr_port.sv ====
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (R01) writing one to pending starts transfer at target index in chosen direction
// (R02) pending stays set during transfer, clears itself on completion
// (R03) after a read, pending clear means data register holds fabric result
// (R04) host leaves command and data registers alone while pending
// (R05) bit 30 read_not_write: 0 write, 1 read, resets 0
// (R06) step-up: data write sets pending, index increments after write done
// (R07) step-up: data read increments index and starts next fabric read
// (R08) step-down: data write sets pending, index decrements after write done
// (R09) step-down: data read decrements index and starts next fabric read
// (R10) host clears stepping enable before its final data read
// (R11) both steps enabled: step-up wins, step-down ignored
// (R12) lane_select bits 19:16 pick written bytes; others left unchanged
// (R13) lane 3 bits 31:24 down to lane 0 bits 7:0
// (R14) host should set all four lanes when stepping
// (R15) bits 15:0 target index, resets zero
// (R16) data read returns fabric result if read_not_write, else last written
// (R17) write delivers data register, lane masked, to fabric at target index
// (R18) command bits 27:20 read zero, ignore writes
module indirect_fabric_csr_port (
  // clock and reset
  input  wire logic                          CLK_SYS_I,
  input  wire logic                          ARST_N_I,
  // wishbone slave
  input  wire logic                          WB_CYC_I,
  input  wire logic                          WB_STB_I,
  input  wire logic                          WB_WE_I,
  input  wire logic [11:0]                   WB_ADR_I,
  input  wire logic [3:0]                    WB_SEL_I,
  input  wire logic [31:0]                   WB_DAT_I,
  output logic      [31:0]                   WB_DAT_O,
  output logic                               WB_ACK_O,
  // fabric register space
  output fabric_csr_pkg::fabric_req_type     FAB_REQ_O,
  input  wire fabric_csr_pkg::fabric_rsp_type FAB_RSP_I,
  // the fabric's current contents at FAB_REQ_O.index, for lane merge
  input  wire logic [31:0]                   FAB_CUR_I
);
  import fabric_csr_pkg::*;

  logic                 pend_reg;
  logic                 rnw_reg;
  logic                 up_reg;
  logic                 dn_reg;
  logic [3:0]           lane_reg;
  logic [15:0]          index_reg;
  logic [31:0]          wdata_reg;
  logic [31:0]          rdata_reg;
  logic                 ack_reg;
  logic [31:0]          dat_reg;
  xfer_state_type       state_reg;
  xfer_state_type       state_next;
  logic [31:0]          merged;
  logic [31:0]          cmd_word;

  // byte-lane write of a bus word into a stored word
  function automatic logic [31:0] sel_write(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int n = 0; n < 4; n++) begin
      if (sel[n]) begin
        r[n*8 +: 8] = wd[n*8 +: 8];
      end
    end
    return r;
  endfunction

  // next index after a step; step-up has precedence
  function automatic logic [15:0] step_index(input logic [15:0] idx, input logic up,
                                             input logic dn);
    logic [15:0] r;
    r = idx;
    if (up) begin
      r = idx + INDEX_ONE; // [R11]
    end else if (dn) begin
      r = idx - INDEX_ONE;
    end
    return r;
  endfunction

  // bus decode: request accepted in the cycle before ack is raised
  wire bus_take = WB_CYC_I && WB_STB_I && !ack_reg;
  wire wr_cmd   = bus_take && WB_WE_I && (WB_ADR_I == CMD_REG_ADDR);
  wire wr_data  = bus_take && WB_WE_I && (WB_ADR_I == DATA_REG_ADDR);
  wire rd_data  = bus_take && !WB_WE_I && (WB_ADR_I == DATA_REG_ADDR);
  wire stepping = up_reg || dn_reg;
  wire xfer_end = state_reg == ST_WAIT && FAB_RSP_I.done;

  // start sources: explicit pending write, or stepping data access
  wire start_cmd  = wr_cmd && WB_SEL_I[3] && WB_DAT_I[PEND_BIT]; // [R01]
  wire start_wr   = wr_data && stepping;                          // [R06] [R08]
  wire start_rd   = rd_data && stepping;                          // [R07] [R09]
  wire start_xfer = !pend_reg && (start_cmd || start_wr || start_rd);

  // command write image, so the index bytes follow the bus lanes
  assign cmd_word = sel_write({16'h0000, index_reg}, WB_DAT_I, WB_SEL_I);

  // single wait-state ack; classic cycle drops ack after one beat
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_take;
    end
  end
  assign WB_ACK_O = ack_reg;

  // read mux; unmapped addresses read zero
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dat_reg <= DATA_RESET;
    end else if (bus_take && !WB_WE_I) begin
      if (WB_ADR_I == CMD_REG_ADDR) begin
        dat_reg <= {pend_reg, rnw_reg, up_reg, dn_reg, 8'h00,
                    lane_reg, index_reg}; // [R18]
      end else if (WB_ADR_I == DATA_REG_ADDR) begin
        dat_reg <= rnw_reg ? rdata_reg : wdata_reg; // [R16]
      end else begin
        dat_reg <= DATA_RESET;
      end
    end
  end
  assign WB_DAT_O = dat_reg;

  // command fields; writes ignored while busy so a live transfer stays stable
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rnw_reg  <= 1'b0; // [R05]
      up_reg   <= 1'b0;
      dn_reg   <= 1'b0;
      lane_reg <= LANE_RESET;
    end else if (wr_cmd && !pend_reg) begin // [R04]
      if (WB_SEL_I[3]) begin
        rnw_reg <= WB_DAT_I[RNW_BIT]; // [R05]
        up_reg  <= WB_DAT_I[STEP_UP_BIT];
        dn_reg  <= WB_DAT_I[STEP_DN_BIT];
      end
      if (WB_SEL_I[2]) begin
        lane_reg <= WB_DAT_I[LANE_LSB +: LANE_W]; // [R12]
      end
    end
  end

  // target index: host write, step on data read, step after write done
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      index_reg <= INDEX_RESET; // [R15]
    end else if (wr_cmd && !pend_reg) begin
      index_reg <= cmd_word[INDEX_W-1:0]; // [R15]
    end else if (start_rd && !pend_reg) begin // live transfer keeps its index
      index_reg <= step_index(index_reg, up_reg, dn_reg); // [R07] [R09]
    end else if (xfer_end && !rnw_reg) begin
      index_reg <= step_index(index_reg, up_reg, dn_reg); // [R06] [R08]
    end
  end

  // host data word
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wdata_reg <= DATA_RESET;
    end else if (wr_data && !pend_reg) begin
      wdata_reg <= sel_write(wdata_reg, WB_DAT_I, WB_SEL_I);
    end
  end

  // fabric read result, captured at completion
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_reg <= DATA_RESET;
    end else if (xfer_end && rnw_reg) begin
      rdata_reg <= FAB_RSP_I.rdata; // [R03]
    end
  end

  // pending flag: self-set on start, self-clear on completion
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pend_reg <= 1'b0;
    end else if (start_xfer) begin
      pend_reg <= 1'b1; // [R01]
    end else if (xfer_end) begin
      pend_reg <= 1'b0; // [R02]
    end
  end

  // sequencer: issue a one-cycle request, then wait for done
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_xfer) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (FAB_RSP_I.done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // lane merge against the fabric's current word keeps unselected bytes
  lane_merge u_merge (
    .old_i    (FAB_CUR_I),
    .new_i    (wdata_reg),
    .lanes_i  (lane_reg),
    .merged_o (merged)
  );

  // fabric request; fields presented from registers, write data merged with FAB_CUR_I, strobe is the req state
  always_comb begin
    FAB_REQ_O.req   = state_reg == ST_REQ; // [R01]
    FAB_REQ_O.rnw   = rnw_reg;
    FAB_REQ_O.index = index_reg;
    FAB_REQ_O.lanes = lane_reg;
    FAB_REQ_O.wdata = merged; // [R17]
  end

  // assertions
  chk_start_sets_pend: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    start_xfer |=> pend_reg && FAB_REQ_O.req) // [R01]
    else $error("start did not raise pending and request");
  chk_pend_holds: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (pend_reg && !xfer_end) |=> pend_reg) // [R02]
    else $error("pending dropped before completion");
  chk_pend_clears: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    xfer_end |=> !pend_reg && state_reg == ST_IDLE) // [R02]
    else $error("pending not cleared at completion");
  chk_read_result: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (xfer_end && rnw_reg) |=> rdata_reg == $past(FAB_RSP_I.rdata)) // [R03]
    else $error("read result not captured");
  chk_rnw_fixed: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    FAB_REQ_O.req |-> FAB_REQ_O.rnw == rnw_reg && pend_reg) // [R05]
    else $error("request direction mismatch");
  chk_up_after_wr: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (xfer_end && !rnw_reg && up_reg && !wr_cmd) |=>
      index_reg == $past(index_reg) + INDEX_ONE) // [R06]
    else $error("index not incremented after write");
  chk_step_on_read: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (start_rd && !pend_reg && up_reg) |=>
      index_reg == $past(index_reg) + INDEX_ONE && FAB_REQ_O.req) // [R07]
    else $error("read step did not increment and issue");
  chk_dn_on_read: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (start_rd && !pend_reg && dn_reg && !up_reg) |=>
      index_reg == $past(index_reg) - INDEX_ONE) // [R09]
    else $error("read step did not decrement");
  chk_up_wins: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (start_rd && !pend_reg && dn_reg && up_reg) |=> index_reg == $past(index_reg) + INDEX_ONE) // [R11]
    else $error("step-down overrode step-up");
  chk_lane_mask: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (FAB_REQ_O.req && !lane_reg[0]) |-> FAB_REQ_O.wdata[7:0] == FAB_CUR_I[7:0]) // [R12]
    else $error("unselected byte overwritten");
  chk_resv_zero: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (ack_reg && $past(WB_ADR_I) == CMD_REG_ADDR && !$past(WB_WE_I)) |->
      WB_DAT_O[27:20] == 8'h00) // [R18]
    else $error("reserved bits nonzero");
  chk_data_readback: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (rd_data && !rnw_reg) |=> WB_DAT_O == $past(wdata_reg)) // [R16]
    else $error("data readback wrong");
  chk_result_read: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (rd_data && rnw_reg) |=> WB_DAT_O == $past(rdata_reg)) // [R16]
    else $error("fabric result not returned");

  // request strobe lifetime
  chk_req_single: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    FAB_REQ_O.req |=> !FAB_REQ_O.req) // [R01]
    else $error("request strobe longer than one cycle");
  chk_req_has_pend: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    FAB_REQ_O.req |-> pend_reg) // [R02]
    else $error("request without pending");
  chk_wait_holds: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (state_reg == ST_WAIT && !FAB_RSP_I.done) |=> state_reg == ST_WAIT && pend_reg) // [R02]
    else $error("wait left before done");

  // host writes refused while a transfer is live
  chk_cmd_locked: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (pend_reg && wr_cmd) |=> rnw_reg == $past(rnw_reg) && lane_reg == $past(lane_reg)) // [R04]
    else $error("command changed while pending");
  chk_data_locked: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (pend_reg && wr_data) |=> wdata_reg == $past(wdata_reg)) // [R04]
    else $error("data changed while pending");
  chk_index_locked: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (pend_reg && !xfer_end) |=> index_reg == $past(index_reg)) // [R04]
    else $error("index moved during transfer");

  // command field updates
  chk_cmd_fields: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (wr_cmd && !pend_reg && WB_SEL_I[3]) |=> rnw_reg == $past(WB_DAT_I[RNW_BIT])) // [R05]
    else $error("direction bit not written");
  chk_index_write: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (wr_cmd && !pend_reg && WB_SEL_I[1] && WB_SEL_I[0]) |=>
      index_reg == $past(WB_DAT_I[INDEX_W-1:0])) // [R15]
    else $error("index not written");
  chk_lane_write: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (wr_cmd && !pend_reg && WB_SEL_I[2]) |=>
      lane_reg == $past(WB_DAT_I[LANE_LSB +: LANE_W])) // [R12]
    else $error("lane select not written");

  // stepping starts and index moves after writes
  chk_up_on_write: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (wr_data && up_reg && !pend_reg) |=> pend_reg) // [R06]
    else $error("step-up data write did not start");
  chk_dn_on_write: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (wr_data && dn_reg && !pend_reg) |=> pend_reg) // [R08]
    else $error("step-down data write did not start");
  chk_dn_after_wr: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (xfer_end && !rnw_reg && dn_reg && !up_reg) |=> index_reg == $past(index_reg) - INDEX_ONE) // [R08]
    else $error("index not decremented after write");
  chk_up_wins_wr: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (xfer_end && !rnw_reg && up_reg && dn_reg) |=> index_reg == $past(index_reg) + INDEX_ONE) // [R11]
    else $error("step-down won after write");
  chk_no_step_idle: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (xfer_end && !up_reg && !dn_reg) |=> index_reg == $past(index_reg)) // [R15]
    else $error("index moved without stepping");
  chk_pend_after_rd: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (start_rd && !pend_reg) |=> pend_reg) // [R07]
    else $error("stepped read did not set pending");
  chk_dn_read_issue: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (start_rd && !pend_reg && dn_reg && !up_reg) |=> FAB_REQ_O.req) // [R09]
    else $error("step-down read not issued");

  // write word presented to the fabric
  chk_lane_take: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (FAB_REQ_O.req && lane_reg[3]) |-> FAB_REQ_O.wdata[31:24] == wdata_reg[31:24]) // [R13]
    else $error("selected top byte not taken");
  chk_write_data: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (FAB_REQ_O.req && !FAB_REQ_O.rnw && lane_reg == {LANE_W{1'b1}}) |->
      FAB_REQ_O.wdata == wdata_reg) // [R17]
    else $error("write word differs from data register");
endmodule
`default_nettype wire

// ==== bench/fabric_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  // clock, reset and answer delay
  input  wire logic                           clk_i,
  input  wire logic                           arst_n_i,
  input  wire logic [3:0]                     lat_i,
  // request in, answer and current word out
  input  wire fabric_csr_pkg::fabric_req_type req_i,
  output fabric_csr_pkg::fabric_rsp_type      rsp_o,
  output logic [31:0]                         cur_o
);
  import fabric_csr_pkg::*;
  logic [31:0] mem [0:255];
  logic [3:0]  cnt;
  logic        busy;
  // preset pattern; only index bits 7:0 decode, so upper indices alias
  initial for (int i = 0; i < 256; i++) mem[i] = {24'hC3C35A, 8'(i)};
  assign cur_o = mem[req_i.index[7:0]];  // old bytes for the merge
  // one transfer at a time; idle read data toggles so stale data never matches
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy  <= 1'b0;
      cnt   <= 4'h0;
      rsp_o <= '0;
    end else begin
      rsp_o.done  <= 1'b0;
      rsp_o.rdata <= ~rsp_o.rdata;
      if (req_i.req) begin
        busy <= 1'b1;
        cnt  <= lat_i;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy       <= 1'b0;
        rsp_o.done <= 1'b1;
        if (req_i.rnw)
          rsp_o.rdata <= mem[req_i.index[7:0]];
        else
          mem[req_i.index[7:0]] <= req_i.wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_indirect_fabric_csr_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_indirect_fabric_csr_port;
  import fabric_csr_pkg::*;
  logic           clk, arst_n, cyc, stb, we, ack;
  logic [11:0]    adr;
  logic [3:0]     sel, lat;
  logic [31:0]    wdat, rdat, cur, q, rq, m;
  fabric_req_type req;
  fabric_rsp_type rsp;
  int             err_count, checked;
  logic [31:0]    mode [3] = '{32'h200F_0014, 32'h100F_001E, 32'h300F_0028};
  logic [31:0]    step [3] = '{32'h1, 32'hFFFF_FFFF, 32'h1};

  indirect_fabric_csr_port DUT (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .FAB_REQ_O(req), .FAB_RSP_I(rsp), .FAB_CUR_I(cur));
  fabric_model fab (.clk_i(clk), .arst_n_i(arst_n), .lat_i(lat), .req_i(req),
    .rsp_o(rsp), .cur_o(cur));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) err_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(a == CMD_REG_ADDR ? "command" : "data", e, q);
  endtask

  // poll until pending clears, bounded
  task automatic idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, CMD_REG_ADDR, 32'h0);
      n++;
    end while (q[PEND_BIT] !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
  endtask

  // access that launches a transfer; a read's data is checked against d
  task automatic start(input logic w, input logic [11:0] a, input logic [31:0] d);
    bus(w, a, d);
    rq = q;
    bus(1'b0, CMD_REG_ADDR, 32'h0);
    chk("pending", 32'h1, {31'h0, q[PEND_BIT]});
    idle();
    if (!w) chk("stepped read", d, rq);
  endtask

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // cut a hang short
  initial begin
    #(25 * 20000);
    err_count++;
    wrap_up();
  end

  initial begin
    {arst_n, cyc, stb, we, adr, wdat, err_count, checked} = '0;
    sel = 4'hF;
    lat = 4'h6;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(CMD_REG_ADDR, 32'h0);
    rd(DATA_REG_ADDR, DATA_RESET);
    rd(12'h100, 32'h0);
    bus(1'b1, DATA_REG_ADDR, 32'h1122_3344);
    start(1'b1, CMD_REG_ADDR, 32'h800F_0005);
    rd(DATA_REG_ADDR, 32'h1122_3344);
    start(1'b1, CMD_REG_ADDR, 32'hC000_0007);
    rd(DATA_REG_ADDR, 32'hC3C3_5A07);
    start(1'b1, CMD_REG_ADDR, 32'hC000_0005);
    rd(DATA_REG_ADDR, 32'h1122_3344);
    // each lane alone, then no lane at all
    for (int k = 0; k < 5; k++) begin
      m = 32'h0000_00FF << (8 * k);
      bus(1'b1, DATA_REG_ADDR, 32'hDEAD_BEEF);
      start(1'b1, CMD_REG_ADDR, {12'h800, 4'(1 << k), 16'(10 + k)});
      start(1'b1, CMD_REG_ADDR, {16'hC000, 16'(10 + k)});
      rd(DATA_REG_ADDR, (32'hDEAD_BEEF & m) | ({24'hC3C35A, 8'(10 + k)} & ~m));
    end
    bus(1'b1, CMD_REG_ADDR, 32'h0FF3_0003);
    rd(CMD_REG_ADDR, 32'h0003_0003);
    foreach (mode[j]) begin  // all lanes set while stepping
      bus(1'b1, CMD_REG_ADDR, mode[j]);
      start(1'b1, DATA_REG_ADDR, 32'hA1A1_0000 + j);
      rd(CMD_REG_ADDR, mode[j] + step[j]);
    end
    start(1'b1, CMD_REG_ADDR, 32'hE00F_0014);
    start(1'b0, DATA_REG_ADDR, 32'hA1A1_0000);
    rd(CMD_REG_ADDR, 32'h600F_0015);
    bus(1'b1, CMD_REG_ADDR, 32'h400F_0015);
    rd(DATA_REG_ADDR, 32'hC3C3_5A15);
    rd(CMD_REG_ADDR, 32'h400F_0015);
    start(1'b1, CMD_REG_ADDR, 32'hD00F_001E);
    start(1'b0, DATA_REG_ADDR, 32'hA1A1_0001);
    rd(CMD_REG_ADDR, 32'h500F_001D);
    // writes while pending are dropped; stepping off first so the data write only stores
    bus(1'b1, CMD_REG_ADDR, 32'h000F_0000);
    bus(1'b1, DATA_REG_ADDR, 32'h5555_AAAA);
    bus(1'b1, CMD_REG_ADDR, 32'h800F_0030);
    bus(1'b1, CMD_REG_ADDR, 32'h4000_0031);
    bus(1'b1, DATA_REG_ADDR, 32'h0);
    idle();
    rd(CMD_REG_ADDR, 32'h000F_0030);
    rd(DATA_REG_ADDR, 32'h5555_AAAA);
    lat <= 4'h0;
    bus(1'b1, CMD_REG_ADDR, 32'hC00F_0030);
    idle();
    rd(DATA_REG_ADDR, 32'h5555_AAAA);
    wrap_up();
  end
endmodule
`default_nettype wire
